// ==== hdl/spm_defs.svh ====
// Shared constants for the flash self-programming sequencer and its core end
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// Control register bit positions
`define CTL_EN        0
`define CTL_ERASE     1
`define CTL_WRITE     2
`define CTL_FUSE      3
`define CTL_CLEAR     4
`define CTL_MASK      8'h1f
`define CTL_RESET     8'h00
// Command codes written to the control register
`define CODE_LOAD     8'h01
`define CODE_ERASE    8'h03
`define CODE_WRITE    8'h05
`define CODE_FUSE     8'h09
`define CODE_CLEAR    8'h10
// Windows after a control write, in cycles
`define STORE_WINDOW  3'h4
`define READ_WINDOW   3'h3
// Erase and write time: least time, rounded up to whole cycles
`define CLK_NS        40
`define PROG_NS       3700000
`define PROG_CYC      ((`PROG_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASED_WORD   16'hffff
// Register offsets of the core end
`define REG_PTR       12'h000
`define REG_DATA      12'h004
`define REG_CMD       12'h008
`define REG_STAT      12'h00c
// Command register fields of the core end
`define CMD_STORE     8
`define CMD_LPM       9
// Status register fields of the core end
`define ST_BUSY       0
`define ST_STALL      1
`define ST_REFUSED    2
`endif

// ==== hdl/spm_pkg.sv ====
// Types shared by the sequencer and its core end
package spm_pkg;
	typedef enum logic [1:0] {
		S_IDLE, S_ARMED, S_PROG, S_COMMIT
	} seq_state_t;
	typedef enum logic [2:0] {
		H_IDLE, H_EE, H_CTRL, H_OP, H_WAIT
	} host_state_t;
endpackage

// ==== hdl/spm_if.sv ====
// Link between the processor core end and the flash sequencer
`timescale 1ns/1ns
interface spm_if;
	logic        ctrl_wr;
	logic [7:0]  ctrl_wdata;
	logic [7:0]  ctrl_rdata;
	logic        store;
	logic        load_program_byte;
	logic [15:0] z_ptr;
	logic [15:0] data_word_pair;
	logic [7:0]  lpm_data;
	logic        lpm_valid;
	logic        stall;

	modport device (
		input  ctrl_wr, ctrl_wdata, store, load_program_byte, z_ptr, data_word_pair,
		output ctrl_rdata, lpm_data, lpm_valid, stall
	);
	modport core (
		output ctrl_wr, ctrl_wdata, store, load_program_byte, z_ptr, data_word_pair,
		input  ctrl_rdata, lpm_data, lpm_valid, stall
	);
endinterface

// ==== hdl/page_buffer.sv ====
// Temporary page buffer with one loaded flag per entry
`timescale 1ns/1ns
`include "spm_defs.svh"
module page_buffer #(
	parameter int WORD_BITS = 4
) (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// Control
	input  wire logic                 clear,
	input  wire logic                 wr,
	input  wire logic [WORD_BITS-1:0] wr_idx,
	input  wire logic [15:0]          wr_data,
	// Read side
	input  wire logic [WORD_BITS-1:0] rd_idx,
	output logic      [15:0]          rd_data,
	output logic                      any_loaded
);
	localparam int WORDS = 1 << WORD_BITS;

	logic [15:0]      word_q [WORDS];
	logic [WORDS-1:0] loaded;

	// One entry per slot; a load in the clear cycle still lands
	genvar i;
	generate
		for (i = 0; i < WORDS; i++) begin : g_entry
			wire hit = wr && (wr_idx == WORD_BITS'(i));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					word_q[i] <= `ERASED_WORD;
					loaded[i] <= 1'b0;
				end else if (hit && !loaded[i]) begin // [R12] [R8]
					word_q[i] <= wr_data;
					loaded[i] <= 1'b1;
				end else if (clear) begin
					word_q[i] <= `ERASED_WORD;
					loaded[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Read mux and occupancy
	assign rd_data    = word_q[rd_idx];
	assign any_loaded = |loaded;
endmodule

// ==== hdl/flash_seq_device.sv ====
// Flash self-programming sequencer: page buffer, erase, write, reads
//
// Overview of operation
// R1 - Store accepted only with fuse programmed zero
// R2 - Software erases page before writing it
// R3 - Buffer loads one word per store
// R4 - Code 03 plus store erases page
// R5 - Core stalled through whole page erase
// R6 - Code 01 plus store loads word
// R7 - Buffer cleared after write, clear bit, reset
// R8 - Each buffer entry loaded once per clear
// R9 - EEPROM write discards loaded buffer words
// R10 - Code 05 plus store writes page
// R11 - Core stalled through whole page write
// R12 - Buffer entries load in any order
// R13 - Erase and write use same page
// R14 - Low pointer bits word, high page
// R15 - Byte reads use pointer bit zero
// R16 - EEPROM busy blocks programming and fuse reads
// R17 - Software checks EEPROM busy before control
// R18 - Command bits clear on completion or timeout
// R19 - Missed store window cancels command cleanly
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "spm_defs.svh"
module flash_seq_device #(
	parameter int          WORD_BITS   = 4,
	parameter int          PAGE_BITS   = 5,
	parameter int unsigned PROG_CYCLES = `PROG_CYC
) (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Link to the core
	spm_if.device           bus,
	// Strap and neighbour status, same clock
	input  wire logic       self_program_fuse,
	input  wire logic       eeprom_write_busy_flag,
	input  wire logic [7:0] fuse_lock_byte
);
	localparam int AW    = WORD_BITS + PAGE_BITS;
	localparam int WORDS = 1 << AW;

	spm_pkg::seq_state_t  state;
	logic [7:0]           ctrl;
	logic [2:0]           win_cnt;
	logic [31:0]          prog_cnt;
	logic [WORD_BITS-1:0] commit_idx;
	logic [PAGE_BITS-1:0] op_page;
	logic                 op_write;
	logic                 fuse_ok;
	logic                 ee_q;
	logic                 stall;
	logic [7:0]           lpm_data;
	logic                 lpm_valid;
	logic [15:0]          flash [WORDS];

	// Pointer split into word and page fields
	wire [WORD_BITS-1:0] z_word = bus.z_ptr[WORD_BITS:1]; // [R14]
	wire [PAGE_BITS-1:0] z_page = bus.z_ptr[AW:WORD_BITS+1]; // [R14]
	wire [AW-1:0]        z_addr = bus.z_ptr[AW:1];

	// Control writes are refused whole while the EEPROM is busy
	wire ee_busy   = eeprom_write_busy_flag;
	wire ctrl_take = bus.ctrl_wr && (state == spm_pkg::S_IDLE)
		&& !ee_busy; // [R16]
	wire arm       = ctrl_take && bus.ctrl_wdata[`CTL_EN];
	wire [7:0] ctrl_in = bus.ctrl_wdata & `CTL_MASK
		& ~(8'h01 << `CTL_CLEAR);

	// Command decode while armed
	wire armed     = (state == spm_pkg::S_ARMED);
	// A busy EEPROM also blocks the store and the fuse read
	wire store_ok  = armed && bus.store && fuse_ok // [R1]
		&& !ee_busy; // [R16]
	wire do_load   = store_ok && (ctrl == `CODE_LOAD); // [R6] [R3]
	wire do_erase  = store_ok && (ctrl == `CODE_ERASE); // [R4]
	wire do_write  = store_ok && (ctrl == `CODE_WRITE); // [R10]
	wire do_fuse   = armed && bus.load_program_byte && (ctrl == `CODE_FUSE)
		&& (win_cnt > (`STORE_WINDOW - `READ_WINDOW))
		&& !ee_busy; // [R16]
	wire win_end   = armed && (win_cnt == 3'h1); // [R18] [R19]

	// Page commit runs one word per cycle after the program time
	wire committing  = (state == spm_pkg::S_COMMIT);
	wire commit_last = committing && (&commit_idx);

	// EEPROM write starting mid-load drops what was loaded
	wire ee_start  = ee_busy && !ee_q;
	wire buf_any;
	wire buf_clear = (ctrl_take && bus.ctrl_wdata[`CTL_CLEAR]) // [R7]
		|| (commit_last && op_write) // [R7]
		|| (ee_start && buf_any); // [R9]

	wire [15:0] buf_word;
	wire [AW-1:0] commit_addr = {op_page, commit_idx};
	// Writing can only pull bits low, so an unerased page corrupts
	wire [15:0] commit_word = op_write
		? (flash[commit_addr] & buf_word) : `ERASED_WORD;

	// Byte pick within the addressed word
	wire [15:0] rd_word = flash[z_addr];
	wire [7:0]  rd_byte = bus.z_ptr[0] ? rd_word[15:8]
		: rd_word[7:0]; // [R15]

	page_buffer #(
		.WORD_BITS (WORD_BITS)
	) u_buf (
		.pclk       (pclk),
		.presetn    (presetn),
		.clear      (buf_clear),
		.wr         (do_load),
		.wr_idx     (z_word),
		.wr_data    (bus.data_word_pair),
		.rd_idx     (commit_idx),
		.rd_data    (buf_word),
		.any_loaded (buf_any)
	);

	// Strap and edge history; fuse held off until sampled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse_ok <= 1'b0;
			ee_q    <= 1'b0;
		end else begin
			fuse_ok <= (self_program_fuse == 1'b0); // [R1]
			ee_q    <= ee_busy;
		end
	end

	// Sequencer: arm, take store, program, commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= spm_pkg::S_IDLE;
			ctrl       <= `CTL_RESET;
			win_cnt    <= 3'h0;
			prog_cnt   <= 32'h0;
			commit_idx <= '0;
			op_page    <= '0;
			op_write   <= 1'b0;
			stall      <= 1'b0;
		end else begin
			unique case (state)
				spm_pkg::S_IDLE: begin
					if (arm) begin
						ctrl    <= ctrl_in;
						win_cnt <= `STORE_WINDOW;
						state   <= spm_pkg::S_ARMED;
					end
				end
				spm_pkg::S_ARMED: begin
					if (do_erase || do_write) begin
						op_page  <= z_page; // [R4] [R10]
						op_write <= do_write;
						prog_cnt <= PROG_CYCLES - 1;
						stall    <= 1'b1; // [R5] [R11]
						state    <= spm_pkg::S_PROG;
					end else if (bus.store || do_fuse || win_end) begin
						// Any store ends the window, used or not
						ctrl  <= `CTL_RESET; // [R18] [R19]
						state <= spm_pkg::S_IDLE;
					end else begin
						win_cnt <= win_cnt - 3'h1;
					end
				end
				spm_pkg::S_PROG: begin
					if (prog_cnt == 32'h0) begin
						commit_idx <= '0;
						state      <= spm_pkg::S_COMMIT;
					end else begin
						prog_cnt <= prog_cnt - 32'h1;
					end
				end
				spm_pkg::S_COMMIT: begin
					if (commit_last) begin
						stall <= 1'b0; // [R5] [R11]
						ctrl  <= `CTL_RESET; // [R18]
						state <= spm_pkg::S_IDLE;
					end else begin
						commit_idx <= commit_idx + 1'b1;
					end
				end
			endcase
		end
	end

	// Flash array; left unreset like the real cells
	always_ff @(posedge pclk) begin
		if (committing) begin
			flash[commit_addr] <= commit_word;
		end
	end

	// Byte reads, or the fuse byte inside its window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpm_data  <= 8'h00;
			lpm_valid <= 1'b0;
		end else begin
			lpm_valid <= bus.load_program_byte && !stall;
			if (bus.load_program_byte && !stall) begin
				lpm_data <= do_fuse ? fuse_lock_byte // [R16]
					: rd_byte; // [R15]
			end
		end
	end

	// Outputs straight from flops
	assign bus.ctrl_rdata = ctrl;
	assign bus.stall      = stall;
	assign bus.lpm_data   = lpm_data;
	assign bus.lpm_valid  = lpm_valid;
endmodule

// ==== hdl/core_side_host.sv ====
// Core end: APB registers that drive control writes, stores and reads
`timescale 1ns/1ns
`include "spm_defs.svh"
module core_side_host #(
	parameter int WORD_BITS = 4,
	parameter int PAGE_BITS = 5
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to the sequencer
	spm_if.core              bus,
	// EEPROM status, same clock
	input  wire logic        eeprom_write_busy_flag
);
	localparam int AW    = WORD_BITS + PAGE_BITS;
	localparam int WORDS = 1 << WORD_BITS;

	spm_pkg::host_state_t state;
	logic [15:0]          ptr;
	logic [15:0]          data;
	logic [9:0]           cmd;
	logic [7:0]           lpm_byte;
	logic                 refused;
	logic [WORDS-1:0]     loaded_map;
	logic [PAGE_BITS-1:0] erased_page;
	logic                 erased_ok;

	// APB decode
	wire setup  = psel && !penable;
	wire access = psel && penable && pready;
	wire wr     = access && pwrite;
	wire hit    = (paddr == `REG_PTR) || (paddr == `REG_DATA)
		|| (paddr == `REG_CMD) || (paddr == `REG_STAT);
	wire busy   = (state != spm_pkg::H_IDLE);
	wire [31:0] status = {8'h00, bus.ctrl_rdata, lpm_byte, 5'h00,
		refused, bus.stall, busy};
	wire [31:0] rd_mux = (paddr == `REG_PTR)  ? {16'h0000, ptr}
		: (paddr == `REG_DATA) ? {16'h0000, data}
		: (paddr == `REG_CMD)  ? {22'h000000, cmd}
		: (paddr == `REG_STAT) ? status : 32'h0;

	// Command guard: write needs prior erase of same page
	wire [7:0]           code   = pwdata[7:0];
	wire [WORD_BITS-1:0] p_word = ptr[WORD_BITS:1];
	wire [PAGE_BITS-1:0] p_page = ptr[AW:WORD_BITS+1];
	wire bad_write = (code == `CODE_WRITE)
		&& !(erased_ok && (erased_page == p_page)); // [R2] [R13]
	wire bad_load  = (code == `CODE_LOAD) && loaded_map[p_word]; // [R8]
	wire cmd_wr    = wr && (paddr == `REG_CMD) && !busy;
	wire start     = cmd_wr && !bad_write && !bad_load;
	// Write clears the word and byte bits, keeping the page and every bit above it
	wire [15:0] z_out = (cmd[7:0] == `CODE_WRITE)
		? {ptr[15:WORD_BITS+1], {(WORD_BITS+1){1'b0}}} : ptr; // [R10]

	// APB answer prepared in setup so data stands in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata  <= rd_mux;
				pslverr <= !hit;
			end
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr     <= 16'h0;
			data    <= 16'h0;
			cmd     <= 10'h0;
			refused <= 1'b0;
		end else begin
			if (wr && (paddr == `REG_PTR))
				ptr <= pwdata[15:0];
			if (wr && (paddr == `REG_DATA))
				data <= pwdata[15:0];
			if (cmd_wr) begin
				cmd     <= pwdata[9:0];
				refused <= !start;
			end
		end
	end

	// Track loaded entries and the erased page
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_map  <= '0;
			erased_page <= '0;
			erased_ok   <= 1'b0;
		end else if (start && pwdata[`CMD_STORE]) begin
			if (code == `CODE_LOAD)
				loaded_map[p_word] <= 1'b1;
			if (code == `CODE_ERASE) begin
				erased_page <= p_page;
				erased_ok   <= 1'b1;
			end
			if (code == `CODE_WRITE) begin
				loaded_map <= '0;
				erased_ok  <= 1'b0;
			end
		end else if (start && code[`CTL_CLEAR]) begin
			loaded_map <= '0;
		end
	end

	// Link sequence: wait EEPROM idle, control write, store or read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state              <= spm_pkg::H_IDLE;
			bus.ctrl_wr        <= 1'b0;
			bus.ctrl_wdata     <= 8'h00;
			bus.store          <= 1'b0;
			bus.load_program_byte            <= 1'b0;
			bus.z_ptr          <= 16'h0;
			bus.data_word_pair <= 16'h0;
			lpm_byte           <= 8'h00;
		end else begin
			if (bus.lpm_valid)
				lpm_byte <= bus.lpm_data;
			unique case (state)
				spm_pkg::H_IDLE: begin
					if (start)
						state <= spm_pkg::H_EE;
				end
				spm_pkg::H_EE: begin
					if (!eeprom_write_busy_flag) begin // [R17]
						bus.ctrl_wr        <= 1'b1;
						bus.ctrl_wdata     <= cmd[7:0];
						bus.z_ptr          <= z_out;
						bus.data_word_pair <= data;
						state              <= spm_pkg::H_CTRL;
					end
				end
				spm_pkg::H_CTRL: begin
					bus.ctrl_wr <= 1'b0;
					bus.store   <= cmd[`CMD_STORE];
					bus.load_program_byte     <= cmd[`CMD_LPM];
					state       <= spm_pkg::H_OP;
				end
				spm_pkg::H_OP: begin
					bus.store <= 1'b0;
					bus.load_program_byte   <= 1'b0;
					state     <= spm_pkg::H_WAIT;
				end
				spm_pkg::H_WAIT: begin
					if (!bus.stall && !bus.lpm_valid)
						state <= spm_pkg::H_IDLE;
				end
				default: state <= spm_pkg::H_IDLE;
			endcase
		end
	end
endmodule

// ==== verification/seq_link_checker.sv ====
// Assertions on the link between the core end and the sequencer
`timescale 1ns/1ns
`include "spm_defs.svh"
module seq_link_checker #(
	parameter int WORD_BITS   = 4,
	parameter int PROG_CYCLES = 8
) (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Link signals
	input wire logic       ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic       store,
	input wire logic       load_program_byte,
	input wire logic       lpm_valid,
	input wire logic       stall,
	// Straps
	input wire logic       self_program_fuse,
	input wire logic       eeprom_write_busy_flag
);
	localparam int STALL_LEN = PROG_CYCLES + (1 << WORD_BITS);
	logic [31:0] run_len;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Length of the current stall run, zero while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_len <= '0;
		else
			run_len <= stall ? run_len + 32'h1 : 32'h0;
	end

	erase_start_a: assert property (ctrl_wr && ctrl_wdata == `CODE_ERASE
		&& !stall && !self_program_fuse && !eeprom_write_busy_flag
		##1 store && !eeprom_write_busy_flag |=> stall)
		else $error("erase did not stall the core");
	stall_length_a: assert property ($fell(stall) |->
		run_len == STALL_LEN) else $error("stall run length wrong");
	stall_cap_a: assert property (stall |-> run_len < STALL_LEN)
		else $error("stall too long");
	fuse_gate_a: assert property ($rose(stall) |-> !self_program_fuse)
		else $error("store accepted with fuse unprogrammed");
	ee_block_a: assert property ($rose(stall) |-> $past(store) &&
		!$past(eeprom_write_busy_flag) &&
		!$past(eeprom_write_busy_flag, 2))
		else $error("programming started beside EEPROM write");
	load_quiet_a: assert property (ctrl_wr && !stall &&
		ctrl_wdata == `CODE_LOAD ##1 store |=> !stall [*2])
		else $error("buffer load stalled the core");
	window_miss_a: assert property (ctrl_wr && ctrl_wdata[0] &&
		!stall ##1 !store [*4] |=> ctrl_rdata == 8'h00 && !stall)
		else $error("command not cancelled after window");
	ctrl_echo_a: assert property (ctrl_wr && ctrl_wdata[0] && !stall
		&& !eeprom_write_busy_flag && !self_program_fuse |=>
		ctrl_rdata == (ctrl_wdata & `CTL_MASK))
		else $error("control register not loaded");
	valid_follows_a: assert property (load_program_byte && !stall |=> lpm_valid)
		else $error("byte read not answered");

	// Main scenarios seen
	cover property ($fell(stall));
	cover property (ctrl_wr && ctrl_wdata[0] ##1 !store [*4]);
	cover property (lpm_valid);
endmodule

// ==== verification/self_program_flash_sequencer_test.sv ====
// Testbench for the sequencer and its core end joined by the link
`timescale 1ns/1ns
`include "spm_defs.svh"
module self_program_flash_sequencer_test;
	localparam int PROG = 8;
	localparam int STALL_LEN = PROG + 16;
	// Clock, reset and APB
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Straps and bench state
	logic        self_program_fuse;
	logic        ee_busy;
	logic [7:0]  fuse_byte;
	logic [31:0] rnd;
	logic [31:0] q;
	logic        err;
	logic [4:0]  pg;
	logic [3:0]  w;
	logic [15:0] page_words [16];
	int          num_errors;
	int          n_compared;
	int          stall_cnt;
	int          cycles;

	spm_if bus ();
	flash_seq_device #(.WORD_BITS(4), .PAGE_BITS(5), .PROG_CYCLES(PROG))
	u_flash_seq_device (.pclk(pclk), .presetn(presetn), .bus(bus),
		.self_program_fuse(self_program_fuse),
		.eeprom_write_busy_flag(ee_busy), .fuse_lock_byte(fuse_byte));
	core_side_host #(.WORD_BITS(4), .PAGE_BITS(5)) u_core_side_host (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(bus),
		.eeprom_write_busy_flag(ee_busy));
	seq_link_checker #(.WORD_BITS(4), .PROG_CYCLES(PROG)) u_seq_link_checker (
		.pclk(pclk), .presetn(presetn), .ctrl_wr(bus.ctrl_wr),
		.ctrl_wdata(bus.ctrl_wdata), .ctrl_rdata(bus.ctrl_rdata),
		.store(bus.store), .load_program_byte(bus.load_program_byte), .lpm_valid(bus.lpm_valid),
		.stall(bus.stall), .self_program_fuse(self_program_fuse),
		.eeprom_write_busy_flag(ee_busy));

	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Stall length meter and hang guard
	always @(posedge pclk) begin
		cycles++;
		if (bus.stall === 1'b1)
			stall_cnt++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end

	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Page in the high bits, word below, byte select at bit zero
	function automatic logic [15:0] zaddr(input logic [4:0] p,
		input logic [3:0] wd, input logic hi);
		return {6'h00, p, wd, hi};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s", $time, msg);
			num_errors++;
		end
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Issue a command, then poll busy
	task automatic cmd(input logic [9:0] c);
		apb(1'b1, `REG_CMD, {22'h0, c});
		q = 32'h1;
		while (q[0] !== 1'b0)
			apb(1'b0, `REG_STAT, 32'h0);
	endtask

	task automatic put(input logic [4:0] p, input logic [3:0] wd,
		input logic [15:0] d);
		apb(1'b1, `REG_PTR, {16'h0, zaddr(p, wd, 1'b0)});
		apb(1'b1, `REG_DATA, {16'h0, d});
		cmd({2'b01, `CODE_LOAD});
	endtask

	task automatic prog(input logic [4:0] p, input logic [9:0] c,
		input logic [3:0] wd, input int exp_len);
		apb(1'b1, `REG_PTR, {16'h0, zaddr(p, wd, 1'b0)});
		stall_cnt = 0;
		cmd(c);
		chk(stall_cnt, exp_len, "stall length");
	endtask

	// Read both bytes of one flash word
	task automatic peek(input logic [4:0] p, input logic [3:0] wd,
		input logic [15:0] exp);
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, `REG_PTR, {16'h0, zaddr(p, wd, h[0])});
			cmd(10'h200);
			apb(1'b0, `REG_STAT, 32'h0);
			chk({24'h0, q[15:8]}, {24'h0, h[0] ? exp[15:8] : exp[7:0]},
				"flash byte");
		end
	endtask

	task automatic rst(input logic f);
		presetn <= 1'b0;
		self_program_fuse <= f;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	task automatic close_out();
		$display("counts: %0d compared, %0d errors", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		self_program_fuse = 1'b1;
		ee_busy = 1'b0;
		fuse_byte = 8'h00;
		rnd = 32'h6424;
		{num_errors, n_compared, stall_cnt, cycles} = '0;
		rst(1'b1);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q, 32'h0, "status after reset");
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped access");
		$display("reset test done");
		prog(5'h03, {2'b01, `CODE_ERASE}, 4'h0, 0);
		$display("fuse test done");
		rst(1'b0);
		prog(5'h03, {2'b00, `CODE_ERASE}, 4'h0, 0);
		apb(1'b0, `REG_STAT, 32'h0);
		chk({24'h0, q[23:16]}, 32'h0, "control left set");
		$display("window test done");
		// Fuse byte read inside the read window
		rnd = step(rnd);
		fuse_byte <= rnd[7:0];
		cmd({2'b10, `CODE_FUSE});
		apb(1'b0, `REG_STAT, 32'h0);
		chk({24'h0, q[15:8]}, {24'h0, rnd[7:0]}, "fuse byte");
		$display("fuse read test done");
		// Whole page loaded out of order before the erase
		rnd = step(rnd);
		pg = rnd[4:0];
		for (int i = 0; i < 16; i++) begin
			rnd = step(rnd);
			w = 4'(i * 5 + 3);
			page_words[w] = rnd[15:0];
			put(pg, w, rnd[15:0]);
		end
		prog(pg, {2'b01, `CODE_ERASE}, rnd[19:16], STALL_LEN);
		prog(pg, {2'b01, `CODE_WRITE}, 4'h0, STALL_LEN);
		for (int i = 0; i < 16; i++)
			peek(pg, 4'(i), page_words[i]);
		prog(pg ^ 5'h01, {2'b01, `CODE_ERASE}, 4'h0, STALL_LEN);
		prog(pg ^ 5'h01, {2'b01, `CODE_WRITE}, 4'h0, STALL_LEN);
		peek(pg ^ 5'h01, 4'h3, 16'hffff);
		$display("page test done");
		// Loaded word kept, cleared by the clear bit, lost to EEPROM write
		for (int m = 0; m < 3; m++) begin
			rnd = step(rnd);
			pg = rnd[4:0];
			w = rnd[8:5];
			put(pg, w, rnd[31:16]);
			if (m == 0) begin
				put(pg, w, ~rnd[31:16]);
				chk({31'h0, q[2]}, 32'h1, "second load not refused");
			end
			if (m == 1)
				cmd({2'b00, `CODE_CLEAR});
			if (m == 2) begin
				ee_busy <= 1'b1;
				repeat (3) @(posedge pclk);
				ee_busy <= 1'b0;
				@(posedge pclk);
			end
			prog(pg, {2'b01, `CODE_ERASE}, 4'h0, STALL_LEN);
			prog(pg, {2'b01, `CODE_WRITE}, 4'h0, STALL_LEN);
			peek(pg, w, m == 0 ? rnd[31:16] : 16'hffff);
		end
		$display("discard test done");
		close_out();
	end
endmodule
